// File: verilog/cpu_arith_psw_core.sv
// Arithmetic slice with status word, on-chip external-space store.
// Assumes the core sequencer issues one op at a time and waits for done.
//
// Summary of operation
// - The external-space move reaches only on-chip flash space and a 1024-byte on-chip data RAM.
// - There are no ports for off-chip program or data memory.
// - Software may write the program memory space through the external-space move.
// - Add, add-with-carry and subtract-with-borrow from a bank register finish in one cycle.
// - Those operations with a direct byte source take two cycles.
// - Those operations through an indirect pointer take two cycles.
// - Those operations with an immediate operand take two cycles.
// - Overflow is set by signed add or subtract overflow, a product above 255, or a divide by zero.
// - Overflow is cleared by those instructions when no overflow condition occurs.
// - Parity shows, one enabled cycle after each accumulator update, whether the accumulator holds an odd count of ones.
// - User flag one is a plain software bit with no hardware meaning.
`default_nettype none
`include "arith_psw_defines.svh"
module cpu_arith_psw_core
    import arith_psw_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       op_start,
    input  wire alu_op_t    op_code,
    input  wire src_mode_t  op_src,
    input  wire logic [7:0] operand,
    input  wire logic [7:0] b_operand,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       xs_req,
    input  wire logic       xs_wr,
    input  wire logic       xs_code,
    input  wire logic [15:0] xs_addr,
    input  wire logic [7:0] xs_wdata,
    output logic [7:0]      acc,
    output logic [7:0]      b_result,
    output logic [7:0]      program_status_word,
    output logic            op_done,
    output logic [7:0]      xs_rdata,
    output logic            xs_valid
);
    logic [7:0]  onchip_xdata_ram [0:`ONCHIP_XDATA_RAM_BYTES-1];
    logic [7:0]  flash_space [0:`FLASH_BYTES-1];
    exec_state_t state;
    logic        carry_flag, aux_carry_flag, user_flag_zero, user_flag_one;
    logic        bank_select_high, bank_select_low, overflow_flag, parity_flag;

    function automatic logic needs_two(input src_mode_t m);
        needs_two = (m != SRC_BANK_REG);
    endfunction : needs_two

    wire logic       is_arith  = (op_code == OP_ADD) || (op_code == OP_ADD_WITH_CARRY) || (op_code == OP_SUBTRACT_WITH_BORROW);
    wire logic       cin       = (op_code == OP_ADD) ? 1'b0 : carry_flag;
    wire logic       is_sub    = (op_code == OP_SUBTRACT_WITH_BORROW);
    wire logic [8:0] sum9      = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
    wire logic [8:0] dif9      = {1'b0, acc} - {1'b0, operand} - {8'h00, cin};
    wire logic [4:0] sum5      = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
    wire logic [4:0] dif5      = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
    wire logic [7:0] arith_res = is_sub ? dif9[7:0] : sum9[7:0];
    wire logic       arith_cy  = is_sub ? dif9[8] : sum9[8];
    wire logic       arith_ac  = is_sub ? dif5[4] : sum5[4];
    wire logic       add_ov    = (acc[7] == operand[7]) && (sum9[7] != acc[7]);
    wire logic       sub_ov    = (acc[7] != operand[7]) && (dif9[7] != acc[7]);
    wire logic [15:0] product  = acc * operand;
    wire logic       div_zero  = (b_operand == 8'h00);
    wire logic [7:0] quot      = div_zero ? 8'h00 : acc / b_operand;
    wire logic [7:0] remn      = div_zero ? 8'h00 : acc % b_operand;
    wire logic       psw_hit   = sfr_wr && (sfr_addr == `PSW_ADDR);
    wire logic       go        = clk_en && op_start && (state == ST_IDLE);
    wire logic       finish    = go ? !needs_two(op_src) : (clk_en && state == ST_BUSY);
    wire logic [7:0] next_acc  = (op_code == OP_MUL) ? product[7:0] :
                                 (op_code == OP_DIV) ? quot : arith_res;
    wire logic       next_ov   = (op_code == OP_MUL) ? (product > `MUL_LIMIT) :
                                 (op_code == OP_DIV) ? div_zero :
                                 (is_sub ? sub_ov : add_ov);
    wire logic       apply     = finish && (op_code != OP_NONE);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
        end else if (clk_en) begin
            case (state)
                ST_IDLE: begin
                    if (op_start && needs_two(op_src)) begin
                        state <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            op_done <= 1'b0;
        end else if (clk_en) begin
            op_done <= finish;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            acc      <= 8'h00;
            b_result <= 8'h00;
        end else if (apply) begin
            acc <= next_acc;
            if (op_code == OP_MUL) begin
                b_result <= product[15:8];
            end else if (op_code == OP_DIV) begin
                b_result <= remn;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {carry_flag, aux_carry_flag, user_flag_zero, bank_select_high} <= 4'h0;
            {bank_select_low, overflow_flag, user_flag_one} <= 3'h0;
        end else if (clk_en) begin
            if (psw_hit) begin
                carry_flag       <= sfr_wdata[`BIT_CARRY];
                aux_carry_flag   <= sfr_wdata[`BIT_AUX];
                user_flag_zero   <= sfr_wdata[`BIT_UF0];
                bank_select_high <= sfr_wdata[`BIT_BSH];
                bank_select_low  <= sfr_wdata[`BIT_BSL];
                overflow_flag    <= sfr_wdata[`BIT_OV];
                user_flag_one    <= sfr_wdata[`BIT_UF1];
            end
            if (apply) begin
                overflow_flag <= next_ov;
                if (is_arith) begin
                    carry_flag     <= arith_cy;
                    aux_carry_flag <= arith_ac;
                end else begin
                    carry_flag <= 1'b0;
                end
            end
        end
    end

    assign parity_flag = ^acc;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            program_status_word <= `PSW_RESET;
        end else if (clk_en) begin
            program_status_word <= {carry_flag, aux_carry_flag, user_flag_zero, bank_select_high,
                                    bank_select_low, overflow_flag, user_flag_one, parity_flag};
        end
    end

    // Only on-chip arrays answer the external-space move; there is no off-chip port.
    wire logic xs_go = clk_en && xs_req;
    always_ff @(posedge core_clk) begin
        if (xs_go && xs_wr && !xs_code) begin
            onchip_xdata_ram[xs_addr[`ONCHIP_XDATA_RAM_AW-1:0]] <= xs_wdata;
        end
        if (xs_go && xs_wr && xs_code) begin
            flash_space[xs_addr[`FLASH_AW-1:0]] <= xs_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            xs_rdata <= 8'h00;
            xs_valid <= 1'b0;
        end else if (clk_en) begin
            xs_valid <= xs_req;
            if (xs_req && !xs_wr) begin
                xs_rdata <= xs_code ? flash_space[xs_addr[`FLASH_AW-1:0]]
                                    : onchip_xdata_ram[xs_addr[`ONCHIP_XDATA_RAM_AW-1:0]];
            end
        end
    end

    chk_bank_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
        go && op_src == SRC_BANK_REG |=> op_done)
        else $error("bank op not done in one cycle");
    chk_direct_two_cycle: assert property (@(posedge core_clk) disable iff (reset)
        go && op_src == SRC_DIRECT ##1 clk_en |=> op_done)
        else $error("direct op timing");
    chk_indirect_busy: assert property (@(posedge core_clk) disable iff (reset)
        go && op_src == SRC_INDIRECT |=> !op_done && state == ST_BUSY)
        else $error("indirect op early");
    chk_immediate_busy: assert property (@(posedge core_clk) disable iff (reset)
        go && op_src == SRC_IMMEDIATE |=> state == ST_BUSY)
        else $error("immediate op early");
    chk_mul_ov_set: assert property (@(posedge core_clk) disable iff (reset)
        apply && op_code == OP_MUL && product > `MUL_LIMIT |=> overflow_flag)
        else $error("mul ov missing");
    chk_add_ov_set: assert property (@(posedge core_clk) disable iff (reset)
        apply && op_code == OP_ADD && !acc[7] && !operand[7] && sum9[7] |=> overflow_flag)
        else $error("add ov missing");
    chk_div_ov_clear: assert property (@(posedge core_clk) disable iff (reset)
        apply && op_code == OP_DIV && !div_zero |=> !overflow_flag)
        else $error("div ov not cleared");
    chk_parity_acc: assert property (@(posedge core_clk) disable iff (reset)
        clk_en |=> program_status_word[`BIT_PARITY] == ^$past(acc))
        else $error("parity wrong");
    chk_user_flag_one: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && psw_hit |=> user_flag_one == $past(sfr_wdata[`BIT_UF1]))
        else $error("user flag one not written");
    chk_carry_add: assert property (@(posedge core_clk) disable iff (reset)
        apply && op_code == OP_ADD && !psw_hit |=> carry_flag == $past(sum9[8]))
        else $error("carry wrong");
    chk_borrow_set: assert property (@(posedge core_clk) disable iff (reset)
        apply && is_sub && ({1'b0, acc} < ({1'b0, operand} + {8'h00, cin})) |=> carry_flag)
        else $error("borrow not flagged");
    chk_mul_carry_clear: assert property (@(posedge core_clk) disable iff (reset)
        apply && op_code == OP_MUL |=> !carry_flag)
        else $error("mul carry not cleared");
    chk_xs_valid_next: assert property (@(posedge core_clk) disable iff (reset)
        xs_go |=> xs_valid)
        else $error("external move not answered");
    chk_freeze_hold: assert property (@(posedge core_clk) disable iff (reset)
        !clk_en |=> $stable(acc) && $stable(program_status_word) && $stable(op_done))
        else $error("state moved while clock enable low");
endmodule : cpu_arith_psw_core
`default_nettype wire

// File: verilog/arith_psw_defines.svh
// Constants for the arithmetic and status-word datapath slice.
// Assumes inclusion by bare name from the core module.
`ifndef ARITH_PSW_DEFINES_SVH
`define ARITH_PSW_DEFINES_SVH
`define PSW_ADDR        8'hd0
`define PSW_RESET       8'h00
`define BIT_CARRY       7
`define BIT_AUX         6
`define BIT_UF0         5
`define BIT_BSH         4
`define BIT_BSL         3
`define BIT_OV          2
`define BIT_UF1         1
`define BIT_PARITY      0
`define ONCHIP_XDATA_RAM_BYTES      1024
`define ONCHIP_XDATA_RAM_AW         10
`define FLASH_BYTES     8192
`define FLASH_AW        13
`define CYC_ONE         2'h1
`define CYC_TWO         2'h2
`define MUL_LIMIT       16'h00ff
`endif

// File: verilog/arith_psw_pkg.sv
// Types shared by the arithmetic datapath slice.
// Assumes the sequencer of the same core drives the operation codes.
`default_nettype none
package arith_psw_pkg;
    typedef enum logic [2:0] {
        OP_NONE, OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_MUL, OP_DIV
    } alu_op_t;
    typedef enum logic [1:0] {
        SRC_BANK_REG, SRC_DIRECT, SRC_INDIRECT, SRC_IMMEDIATE
    } src_mode_t;
    typedef enum logic {
        ST_IDLE, ST_BUSY
    } exec_state_t;
endpackage : arith_psw_pkg
`default_nettype wire

// File: sim/tb_cpu_arith_psw_core.sv
// Self-checking bench for the arithmetic and status-word slice.
// Assumes the design package and core under verilog/ are compiled first.
`default_nettype none
module tb_cpu_arith_psw_core
    import arith_psw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        op_start = 1'b0;
    logic        clk_en = 1'b1;
    logic        sfr_wr = 1'b0;
    logic        xs_req = 1'b0;
    logic        xs_wr = 1'b0;
    logic        xs_code = 1'b0;
    alu_op_t     op_code = OP_NONE;
    src_mode_t   op_src = SRC_BANK_REG;
    logic [7:0]  operand = 8'h00;
    logic [7:0]  b_operand = 8'h00;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  xs_wdata = 8'h00;
    logic [15:0] xs_addr = 16'h0000;
    logic [7:0]  acc, b_result, program_status_word, xs_rdata;
    logic        op_done, xs_valid;
    int          errors = 0;
    int          cmp_count = 0;
    always #10 core_clk = ~core_clk;
    cpu_arith_psw_core i_cpu_arith_psw_core (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .op_start(op_start), .op_code(op_code), .op_src(op_src), .operand(operand), .b_operand(b_operand),
        .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .xs_req(xs_req), .xs_wr(xs_wr),
        .xs_code(xs_code), .xs_addr(xs_addr), .xs_wdata(xs_wdata), .acc(acc), .b_result(b_result),
        .program_status_word(program_status_word), .op_done(op_done), .xs_rdata(xs_rdata), .xs_valid(xs_valid));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic step(input alu_op_t c, input src_mode_t s, input logic [7:0] a, b, am, ea, pm, ep, input int cyc);
        int n;
        @(negedge core_clk);
        op_code = c;
        op_src = s;
        operand = a;
        b_operand = b;
        op_start = 1'b1;
        @(negedge core_clk);
        op_start = 1'b0;
        n = 1;
        while (op_done !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        if (cyc > 0) check("op cycles", 16'(cyc), 16'(n));
        check("acc", 16'(ea & am), 16'(acc & am));
        check("status flags", 16'(ep), 16'(program_status_word & pm));
    endtask : step
    task automatic sfr(input logic [7:0] ad, d, exp);
        @(negedge core_clk);
        sfr_addr = ad;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
        @(negedge core_clk);
        check("status write", 16'(exp), 16'(program_status_word));
    endtask : sfr
    task automatic xs(input logic w, sp, input logic [15:0] ad, input logic [7:0] d);
        @(negedge core_clk);
        xs_wr = w;
        xs_code = sp;
        xs_addr = ad;
        xs_wdata = d;
        xs_req = 1'b1;
        @(negedge core_clk);
        xs_req = 1'b0;
        check("xs_valid", 16'h0001, 16'(xs_valid));
        if (!w) check("xs_rdata", 16'(d), 16'(xs_rdata));
    endtask : xs
    task automatic test_status;
        check("reset status", 16'h0000, 16'(program_status_word));
        check("reset acc", 16'h0000, 16'(acc));
        sfr(8'hd1, 8'hff, 8'h00);
        sfr(8'hd0, 8'h3a, 8'h3a);
        step(OP_ADD, SRC_BANK_REG, 8'h01, 8'h00, 8'hff, 8'h01, 8'h3b, 8'h3b, 1);
        sfr(8'hd0, 8'h00, 8'h01);
        $display("test_status done");
    endtask : test_status
    task automatic test_arith;
        step(OP_ADD, SRC_BANK_REG, 8'h7f, 8'h00, 8'hff, 8'h80, 8'hff, 8'h45, 1);
        step(OP_ADD, SRC_DIRECT, 8'h80, 8'h00, 8'hff, 8'h00, 8'hff, 8'h84, 2);
        step(OP_ADD_WITH_CARRY, SRC_INDIRECT, 8'h01, 8'h00, 8'hff, 8'h02, 8'hff, 8'h01, 2);
        step(OP_SUBTRACT_WITH_BORROW, SRC_IMMEDIATE, 8'h03, 8'h00, 8'hff, 8'hff, 8'hff, 8'hc0, 2);
        step(OP_SUBTRACT_WITH_BORROW, SRC_BANK_REG, 8'h01, 8'h00, 8'hff, 8'hfd, 8'hff, 8'h01, 1);
        step(OP_ADD_WITH_CARRY, SRC_BANK_REG, 8'h00, 8'h00, 8'hff, 8'hfd, 8'hff, 8'h01, 1);
        step(OP_MUL, SRC_BANK_REG, 8'h02, 8'h00, 8'hff, 8'hfa, 8'h85, 8'h04, 0);
        check("mul high", 16'h0001, 16'(b_result));
        step(OP_DIV, SRC_BANK_REG, 8'h00, 8'h02, 8'hff, 8'h7d, 8'h85, 8'h00, 0);
        check("div remainder", 16'h0000, 16'(b_result));
        step(OP_DIV, SRC_BANK_REG, 8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 8'h04, 0);
        $display("test_arith done");
    endtask : test_arith
    task automatic test_xspace;
        xs(1'b1, 1'b0, 16'h03ff, 8'h5a);
        xs(1'b1, 1'b1, 16'h03ff, 8'ha5);
        xs(1'b0, 1'b0, 16'h03ff, 8'h5a);
        xs(1'b0, 1'b1, 16'h03ff, 8'ha5);
        $display("test_xspace done");
    endtask : test_xspace
    task automatic test_hold;
        @(negedge core_clk);
        op_code = OP_ADD;
        op_src = SRC_DIRECT;
        operand = 8'h11;
        op_start = 1'b1;
        @(negedge core_clk);
        op_start = 1'b0;
        clk_en = 1'b0;
        repeat (3) @(negedge core_clk);
        check("op_done frozen", 16'h0000, 16'(op_done));
        check("acc frozen", 16'h0000, 16'(acc));
        clk_en = 1'b1;
        @(negedge core_clk);
        check("op_done resumed", 16'h0001, 16'(op_done));
        check("acc resumed", 16'h0011, 16'(acc));
        $display("test_hold done");
    endtask : test_hold
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        test_status();
        test_arith();
        test_xspace();
        test_hold();
        summarize();
    end
    initial begin
        #200us;
        errors++;
        summarize();
    end
endmodule : tb_cpu_arith_psw_core
`default_nettype wire
